/* burst_pkg.sv */
// shared constants for the burst latency link and its two ends
`default_nettype none
package burst_pkg;
	localparam int DATA_W        = 16;        // link data width
	localparam int LINK_ADDR_W   = 22;        // link word address width
	localparam int CFG_W         = 16;        // configuration word width
	localparam logic [15:0] CFG_RESET = 16'h1d0f; // variable, code 3, wait high, early
	localparam int CFG_FIXED_BIT = 14;        // 1 = fixed latency
	localparam int CFG_CODE_HI   = 13;        // latency code msb
	localparam int CFG_CODE_LO   = 11;        // latency code lsb
	localparam int CFG_POL_BIT   = 10;        // 1 = wait active high
	localparam int CFG_WC_BIT    = 8;         // 1 = wait one cycle early
	localparam logic [2:0] CODE_MIN    = 3'h2; // smallest legal code
	localparam logic [2:0] VAR_CODE_MAX = 3'h3; // largest variable code
	localparam logic [2:0] FIX_CODE_MAX = 3'h6; // largest fixed code
	localparam logic [7:0] ROW_END_LOW  = 8'hff; // low byte of last word in a row
	localparam int CLK_PERIOD_NS = 25;        // 40 MHz bus clock
	localparam int SELECT_LOW_MAX_NS = 4000;  // longest select-low time
	localparam int SELECT_LOW_MAX_CYCLES = SELECT_LOW_MAX_NS / CLK_PERIOD_NS; // rounds down
	localparam logic [3:0] REFRESH_CYCLES   = 4'h3; // extra wait for a colliding refresh
	localparam logic [3:0] ROW_CROSS_CYCLES = 4'h2; // wait cycles when crossing a row
	localparam int REFRESH_INTERVAL = 64;     // cycles between refresh requests
	// controller register offsets
	localparam logic [7:0] OFF_CONFIG = 8'h00;
	localparam logic [7:0] OFF_ADDR   = 8'h04;
	localparam logic [7:0] OFF_LEN    = 8'h08;
	localparam logic [7:0] OFF_WDATA  = 8'h0c;
	localparam logic [7:0] OFF_CMD    = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	localparam logic [7:0] OFF_RDATA  = 8'h18;
	localparam int CMD_READ_BIT  = 0;         // start a read burst
	localparam int CMD_WRITE_BIT = 1;         // start a write burst
	localparam int CMD_CFG_BIT   = 2;         // program the configuration word
	localparam int LEN_W         = 9;         // burst length field width
endpackage : burst_pkg
`default_nettype wire

/* burst_link_if.sv */
// link between the burst memory and its controller
`default_nettype none
interface burst_link_if;
	logic                             select_n;       // chip select, active low
	logic                             address_valid_strobe_n; // burst launch, active low
	logic                             write_n;        // low = write burst
	logic                             config_enable;  // launch loads the config word
	logic [burst_pkg::LINK_ADDR_W-1:0] addr;           // word address or config word
	logic [burst_pkg::DATA_W-1:0]      host_dq;        // controller data out
	logic                             host_dq_oe;     // controller drives data
	logic [burst_pkg::DATA_W-1:0]      dev_dq;         // memory data out
	logic                             dev_dq_oe;      // memory drives data
	logic                             wait_pin;       // wait output, polarity programmable
	logic [burst_pkg::DATA_W-1:0]      dq;             // resolved data lines
	// memory has priority; a clash is a protocol fault the bench does not check
	assign dq = dev_dq_oe ? dev_dq : host_dq;
	modport device (input select_n, address_valid_strobe_n, write_n, config_enable, addr,
		dq, output dev_dq, dev_dq_oe, wait_pin);
	modport host (output select_n, address_valid_strobe_n, write_n, config_enable, addr,
		host_dq, host_dq_oe, input dq, wait_pin);
endinterface : burst_link_if
`default_nettype wire

/* latency_counter.sv */
// loadable down counter that times latency and row-cross waits
`default_nettype none
module latency_counter #(
	parameter int W = 4
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         load,
	input  wire logic [W-1:0] load_value,
	output logic [W-1:0]      count,
	output logic              last
);
	if (W < 2) begin : g_bad_width
		$error("latency_counter needs at least two bits");
	end
	logic [W-1:0] count_reg; // cycles still to run

	// load wins over the running count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= '0;
		end else if (load) begin
			count_reg <= load_value;
		end else if (count_reg != '0) begin
			count_reg <= count_reg - W'(1);
		end
	end

	assign count = count_reg;
	assign last  = (count_reg == W'(1)); // final cycle of the wait
endmodule : latency_counter
`default_nettype wire

/* burst_memory_end.sv */
// memory end: latency, wait output, interrupts, refresh and row ends
//
// The implementer's own choices: the placing of the registers and the APB register port.
`default_nettype none
module burst_memory_end #(
	parameter int MEM_DEPTH        = 1024,
	parameter int REFRESH_INTERVAL = burst_pkg::REFRESH_INTERVAL
) (
	input  wire logic     pclk,
	input  wire logic     presetn,
	burst_link_if.device  link,
	output logic          refresh_busy,
	output logic          burst_active
);
	localparam int AW = $clog2(MEM_DEPTH);
	localparam int TW = $clog2(REFRESH_INTERVAL + 1);
	// rows must fit, and the depth must be a power of two for the wrap
	if (MEM_DEPTH < 256 || (1 << AW) != MEM_DEPTH || REFRESH_INTERVAL < 2) begin : g_bad
		$error("burst_memory_end parameters out of range");
	end

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00, // deselected or config cycle
		ST_LAT   = 2'b01, // initial latency
		ST_DATA  = 2'b10, // one word per cycle
		ST_CROSS = 2'b11  // row boundary crossing
	} dev_state_t;

	logic [burst_pkg::DATA_W-1:0] mem [MEM_DEPTH]; // storage array
	dev_state_t                   state_reg;       // burst phase
	dev_state_t                   state_next;
	logic [15:0]                  cfg_reg;         // bus configuration word
	logic                         is_write_reg;    // current burst writes
	logic [AW-1:0]                addr_reg;        // word in transfer
	logic [burst_pkg::DATA_W-1:0] dout_reg;        // read data to the link
	logic                         dout_oe_reg;     // read data enable
	logic [TW-1:0]                ref_timer_reg;   // refresh interval timer
	logic                         ref_pending_reg; // refresh owed
	logic [3:0]                   ref_left_reg;    // idle refresh in progress
	logic                         cnt_last;        // counter in final cycle
	logic                         cnt_load;
	logic [3:0]                   cnt_value;

	// decoded link and configuration
	logic       selected;
	logic       launch;
	logic       cfg_write;
	logic       fixed_mode;
	logic [2:0] code;
	logic       read_var;
	logic       take_refresh;
	logic       row_end;
	logic       data_edge;
	logic       wait_act;
	logic       upcoming_invalid;

	assign selected   = ~link.select_n;
	assign launch     = selected & ~link.address_valid_strobe_n & ~link.config_enable;
	assign cfg_write  = selected & ~link.address_valid_strobe_n & link.config_enable;
	assign fixed_mode = cfg_reg[burst_pkg::CFG_FIXED_BIT];
	assign code       = cfg_reg[burst_pkg::CFG_CODE_HI:burst_pkg::CFG_CODE_LO];
	// writes are fixed even in variable mode, so only variable reads stretch
	assign read_var   = link.write_n & ~fixed_mode;
	// a deselected launch may always refresh; a write interrupt may not
	assign take_refresh = launch & (ref_pending_reg | (ref_left_reg != 4'h0))
		& (read_var | (state_reg == ST_IDLE));
	assign row_end    = (addr_reg[7:0] == burst_pkg::ROW_END_LOW);
	// a word moves on this edge unless the burst is cut
	assign data_edge  = (state_reg == ST_DATA) & selected & ~launch & ~cfg_write;

	// latency: code cycles, plus refresh cycles only for a colliding variable read
	always_comb begin
		cnt_load  = 1'b0;
		cnt_value = {1'b0, code} - 4'h1;
		if (launch) begin
			cnt_load = 1'b1;
			if (take_refresh && read_var) begin
				cnt_value = {1'b0, code} + burst_pkg::REFRESH_CYCLES - 4'h1;
			end
		end else if (data_edge && row_end) begin
			cnt_load  = 1'b1;
			cnt_value = burst_pkg::ROW_CROSS_CYCLES;
		end
	end

	latency_counter #(.W(4)) u_lat (
		.pclk       (pclk),
		.presetn    (presetn),
		.load       (cnt_load),
		.load_value (cnt_value),
		.count      (),
		.last       (cnt_last)
	);

	// phase sequencing
	always_comb begin
		state_next = state_reg;
		if (!selected || cfg_write) begin
			state_next = ST_IDLE;
		end else if (launch) begin
			state_next = ST_LAT; // new launch cuts any burst
		end else begin
			case (state_reg)
				ST_LAT:   if (cnt_last) state_next = ST_DATA;
				ST_DATA:  if (row_end) state_next = ST_CROSS;
				ST_CROSS: if (cnt_last) state_next = ST_DATA;
				ST_IDLE:  state_next = ST_IDLE; // only a launch leaves
				default:  state_next = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// configuration word loaded from the address lines
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg <= burst_pkg::CFG_RESET;
		end else if (cfg_write) begin
			cfg_reg <= link.addr[15:0];
		end
	end

	// burst direction and address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			is_write_reg <= 1'b0;
			addr_reg     <= '0;
		end else if (launch) begin
			is_write_reg <= ~link.write_n;
			addr_reg     <= link.addr[AW-1:0];
		end else if (data_edge) begin
			addr_reg <= addr_reg + AW'(1); // crosses into next row
		end
	end

	// write port: a cut write leaves the location untouched
	always_ff @(posedge pclk) begin
		if (data_edge && is_write_reg) begin
			mem[addr_reg] <= link.dq;
		end
	end

	// read data: preload the word due at the next edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dout_reg    <= '0;
			dout_oe_reg <= 1'b0;
		end else begin
			// a launch sends the state back to latency, releasing the lines
			dout_oe_reg <= (state_next == ST_DATA) & ~is_write_reg & ~launch;
			if (state_next == ST_DATA) begin
				dout_reg <= mem[data_edge ? addr_reg + AW'(1) : addr_reg];
			end
		end
	end

	// refresh: requested by the timer, done while idle or folded into latency
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_timer_reg   <= '0;
			ref_pending_reg <= 1'b0;
			ref_left_reg    <= 4'h0;
		end else begin
			if (ref_timer_reg == TW'(REFRESH_INTERVAL - 1)) begin
				ref_timer_reg <= '0;
			end else begin
				ref_timer_reg <= ref_timer_reg + TW'(1);
			end
			if (take_refresh) begin
				ref_left_reg <= 4'h0; // hidden in this burst's latency
			end else if (!selected && ref_pending_reg && ref_left_reg == 4'h0) begin
				ref_left_reg <= burst_pkg::REFRESH_CYCLES;
			end else if (ref_left_reg != 4'h0) begin
				ref_left_reg <= ref_left_reg - 4'h1;
			end
			// a new request wins over the clear in the same cycle
			if (ref_timer_reg == TW'(REFRESH_INTERVAL - 1)) begin
				ref_pending_reg <= 1'b1;
			end else if (take_refresh || (!selected && ref_left_reg == 4'h0)) begin
				ref_pending_reg <= 1'b0;
			end
		end
	end

	// early mode looks one cycle ahead using registered state only
	always_comb begin
		case (state_reg)
			ST_LAT:   upcoming_invalid = ~cnt_last;
			ST_CROSS: upcoming_invalid = ~cnt_last;
			ST_DATA:  upcoming_invalid = row_end;
			default:  upcoming_invalid = 1'b1;
		endcase
	end

	// wait only while selected; idle shows the inactive level
	assign wait_act = selected & (cfg_reg[burst_pkg::CFG_WC_BIT] ? upcoming_invalid
		: (state_reg != ST_DATA));
	assign link.wait_pin  = cfg_reg[burst_pkg::CFG_POL_BIT] ? wait_act : ~wait_act;
	assign link.dev_dq    = dout_reg;
	assign link.dev_dq_oe = dout_oe_reg & selected;
	assign refresh_busy   = (ref_left_reg != 4'h0);
	assign burst_active   = (state_reg != ST_IDLE);
endmodule : burst_memory_end
`default_nettype wire

/* burst_controller_end.sv */
// controller end: APB registers driving bursts over the link
`default_nettype none
module burst_controller_end #(
	parameter int SELECT_LOW_MAX = burst_pkg::SELECT_LOW_MAX_CYCLES
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	burst_link_if.host       link
);
	if (SELECT_LOW_MAX < 16 || SELECT_LOW_MAX > 255) begin : g_bad
		$error("burst_controller_end select limit out of range");
	end
	localparam int LW = burst_pkg::LEN_W;

	typedef enum logic [2:0] {
		H_IDLE   = 3'b000, // waiting for a command
		H_CFG    = 3'b001, // config word launch
		H_LAUNCH = 3'b010, // burst launch cycle
		H_RUN    = 3'b011, // words moving
		H_GAP    = 3'b100  // select high for one cycle
	} host_state_t;

	host_state_t   state_reg;
	logic [15:0]   cfg_word_reg;   // word to program
	logic [15:0]   shadow_reg;     // word last programmed
	logic [burst_pkg::LINK_ADDR_W-1:0] start_reg; // burst start address
	logic [burst_pkg::LINK_ADDR_W-1:0] cur_reg;   // next word address
	logic [LW-1:0] len_reg;        // words per command
	logic [LW-1:0] left_reg;       // words still to move
	logic [15:0]   wdata_reg;      // write pattern base
	logic [15:0]   rdata_reg;      // last word read
	logic [15:0]   dq_out_reg;     // write data on the link
	logic          is_write_reg;
	logic          reject_reg;     // last command refused
	logic          wait_prev_reg;  // wait as seen last cycle
	logic [7:0]    sel_timer_reg;  // cycles in H_RUN, launch cycle not counted
	logic [31:0]   prdata_reg;

	logic       apb_wr;
	logic       wait_now;
	logic       word_edge;
	logic       cmd_ok;
	logic [2:0] new_code;
	logic       code_ok;

	assign apb_wr   = psel & penable & pwrite;
	assign wait_now = shadow_reg[burst_pkg::CFG_POL_BIT] ? link.wait_pin : ~link.wait_pin;
	// latency is unknown, so each word is timed from wait alone
	assign word_edge = (state_reg == H_RUN) &
		~(shadow_reg[burst_pkg::CFG_WC_BIT] ? wait_prev_reg : wait_now);
	assign new_code = cfg_word_reg[burst_pkg::CFG_CODE_HI:burst_pkg::CFG_CODE_LO];
	assign code_ok  = (new_code >= burst_pkg::CODE_MIN) &&
		(new_code <= (cfg_word_reg[burst_pkg::CFG_FIXED_BIT] ? burst_pkg::FIX_CODE_MAX
		: burst_pkg::VAR_CODE_MAX));
	assign cmd_ok   = apb_wr && paddr[7:0] == burst_pkg::OFF_CMD && state_reg == H_IDLE;

	// software-written registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_word_reg <= burst_pkg::CFG_RESET;
			start_reg    <= '0;
			len_reg      <= LW'(1);
			wdata_reg    <= '0;
		end else if (apb_wr) begin
			case (paddr[7:0])
				burst_pkg::OFF_CONFIG: cfg_word_reg <= pwdata[15:0];
				burst_pkg::OFF_ADDR:   start_reg <= pwdata[burst_pkg::LINK_ADDR_W-1:0];
				burst_pkg::OFF_LEN:    len_reg <= pwdata[LW-1:0];
				burst_pkg::OFF_WDATA:  wdata_reg <= pwdata[15:0];
				default:               start_reg <= start_reg; // others have no store
			endcase
		end
	end

	// read data is captured in the setup cycle, so no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= '0;
		end else if (psel && !penable && !pwrite) begin
			case (paddr[7:0])
				burst_pkg::OFF_CONFIG: prdata_reg <= {16'h0000, cfg_word_reg};
				burst_pkg::OFF_ADDR:   prdata_reg <= 32'(start_reg);
				burst_pkg::OFF_LEN:    prdata_reg <= 32'(len_reg);
				burst_pkg::OFF_WDATA:  prdata_reg <= {16'h0000, wdata_reg};
				burst_pkg::OFF_STATUS: prdata_reg <= {7'h00, left_reg, 14'h0000,
					reject_reg, state_reg != H_IDLE};
				burst_pkg::OFF_RDATA:  prdata_reg <= {16'h0000, rdata_reg};
				default:               prdata_reg <= '0;
			endcase
		end
	end
	assign prdata  = prdata_reg;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~(paddr[7:0] <= burst_pkg::OFF_RDATA
		&& paddr[1:0] == 2'b00 && paddr[11:8] == 4'h0);

	// burst sequencing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg     <= H_IDLE;
			shadow_reg    <= burst_pkg::CFG_RESET;
			cur_reg       <= '0;
			left_reg      <= '0;
			is_write_reg  <= 1'b0;
			reject_reg    <= 1'b0;
			dq_out_reg    <= '0;
			rdata_reg     <= '0;
			sel_timer_reg <= '0;
			wait_prev_reg <= 1'b0;
		end else begin
			wait_prev_reg <= wait_now;
			sel_timer_reg <= (state_reg == H_RUN) ? sel_timer_reg + 8'h01 : 8'h00;
			case (state_reg)
				H_IDLE: begin
					if (cmd_ok && pwdata[burst_pkg::CMD_CFG_BIT]) begin
						reject_reg <= ~code_ok;
						if (code_ok) state_reg <= H_CFG;
					end else if (cmd_ok && pwdata[1:0] != 2'b00 && len_reg != '0) begin
						reject_reg   <= 1'b0;
						is_write_reg <= pwdata[burst_pkg::CMD_WRITE_BIT];
						cur_reg      <= start_reg;
						left_reg     <= len_reg;
						dq_out_reg   <= wdata_reg;
						state_reg    <= H_LAUNCH;
					end else if (apb_wr && paddr[7:0] == burst_pkg::OFF_CMD) begin
						reject_reg <= 1'b1;
					end
				end
				H_CFG: begin
					shadow_reg <= cfg_word_reg;
					state_reg  <= H_GAP;
				end
				H_LAUNCH: state_reg <= H_RUN;
				H_RUN: begin
					if (word_edge) begin
						if (!is_write_reg) rdata_reg <= link.dq;
						dq_out_reg <= dq_out_reg + 16'h0001;
						cur_reg    <= cur_reg + burst_pkg::LINK_ADDR_W'(1);
						left_reg   <= left_reg - LW'(1);
						// stop at row end or before the select-low limit
						if (left_reg == LW'(1)
							|| cur_reg[7:0] == burst_pkg::ROW_END_LOW
							|| sel_timer_reg >= 8'(SELECT_LOW_MAX - 2)) begin
							state_reg <= H_GAP;
						end
					end
				end
				// restart only after a data cycle, by toggling select
				H_GAP:   state_reg <= (left_reg != '0) ? H_LAUNCH : H_IDLE;
				default: state_reg <= H_IDLE;
			endcase
		end
	end

	// link drive decoded from the state
	assign link.select_n = ~(state_reg == H_CFG || state_reg == H_LAUNCH
		|| state_reg == H_RUN);
	assign link.address_valid_strobe_n = ~(state_reg == H_CFG || state_reg == H_LAUNCH);
	assign link.config_enable = (state_reg == H_CFG);
	assign link.write_n    = ~is_write_reg;
	// the new word alone; mixing in the old one would corrupt mode and code bits
	assign link.addr       = (state_reg == H_CFG) ? burst_pkg::LINK_ADDR_W'(cfg_word_reg)
		: cur_reg;
	assign link.host_dq    = dq_out_reg;
	assign link.host_dq_oe = is_write_reg & (state_reg == H_LAUNCH || state_reg == H_RUN);
endmodule : burst_controller_end
`default_nettype wire

/* burst_link_checker.sv */
// link checker: latency, wait level, select time and launch order
`default_nettype none
module burst_link_checker #(
	parameter int SEL_MAX = 160
) (
	input wire logic                              pclk,
	input wire logic                              presetn,
	input wire logic                              select_n,
	input wire logic                              address_valid_strobe_n,
	input wire logic                              write_n,
	input wire logic                              config_enable,
	input wire logic [burst_pkg::LINK_ADDR_W-1:0] addr,
	input wire logic                              dev_dq_oe,
	input wire logic                              wait_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        launch;  // strobe seen with select low
	logic [15:0] cfg_reg; // shadow of the memory config word
	logic [2:0]  code;    // programmed latency code
	logic        rpend;   // read launched, first word not out yet
	logic [4:0]  cnt;     // cycles since the read launch
	logic [7:0]  cur;     // low byte of the word on the lines
	logic [15:0] sel_cnt; // cycles with select low
	logic        wact;    // wait at its active level
	assign launch = !select_n && !address_valid_strobe_n;
	assign code = cfg_reg[burst_pkg::CFG_CODE_HI:burst_pkg::CFG_CODE_LO];
	assign wact = (wait_pin == cfg_reg[burst_pkg::CFG_POL_BIT]);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// shadow config, loaded by a config launch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) cfg_reg <= burst_pkg::CFG_RESET;
		else if (launch && config_enable) cfg_reg <= addr[15:0];
	end
	// read latency count, stops at the first word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) rpend <= 1'b0;
		else if (launch && !config_enable && write_n) rpend <= 1'b1;
		else if (dev_dq_oe) rpend <= 1'b0;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) cnt <= 5'h0;
		else if (launch) cnt <= 5'h1;
		else if (rpend) cnt <= cnt + 5'h1;
	end
	// word address tracking, only the row byte matters
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) cur <= 8'h0;
		else if (launch) cur <= addr[7:0];
		else if (dev_dq_oe) cur <= cur + 8'h1;
	end
	// select low time; wide so it cannot wrap within a run
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) sel_cnt <= 16'h0;
		else sel_cnt <= select_n ? 16'h0 : sel_cnt + 16'h1;
	end
	AST_SEL_LIMIT: assert property (sel_cnt <= SEL_MAX)
		else $error("select held low too long");
	AST_FIX_LATENCY: assert property (rpend && dev_dq_oe && cfg_reg[14] |-> cnt == {2'b0, code})
		else $error("fixed read latency differs from code");
	AST_VAR_LATENCY: assert property (rpend && dev_dq_oe && !cfg_reg[14] |->
		cnt == {2'b0, code} || cnt == {2'b0, code} + 5'h3)
		else $error("variable read latency out of range");
	AST_LAUNCH_RELEASE: assert property (launch && !config_enable |=> !dev_dq_oe)
		else $error("data lines driven after a launch");
	AST_NO_EARLY_RELAUNCH: assert property (launch |-> !rpend)
		else $error("relaunch before first read word");
	AST_CODE_LEGAL: assert property (launch && config_enable |-> addr[13:11] >= 3'h2 &&
		addr[13:11] <= (addr[14] ? 3'h6 : 3'h3))
		else $error("reserved latency code loaded");
	AST_DATA_NO_WAIT: assert property (!cfg_reg[8] && dev_dq_oe |-> !wact)
		else $error("wait active with valid data");
	AST_DELAY_WAIT: assert property (!cfg_reg[8] && rpend && !dev_dq_oe && !select_n |-> wact)
		else $error("wait inactive during latency");
	AST_IDLE_WAIT: assert property (select_n [*3] |-> !wact)
		else $error("wait active while deselected");
	AST_ROW_END: assert property (dev_dq_oe && cur == 8'hff |-> ##[1:2] select_n)
		else $error("burst ran past the row end");
endmodule : burst_link_checker
`default_nettype wire

/* burst_latency_wait_control_tb.sv */
// bench: both link ends joined, driven over APB
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
	$display("ERROR %0t: got %h exp %h", $time, g, e); end end
module burst_latency_wait_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        refresh_busy, burst_active; // observed only
	int          err_count, n_compared;
	logic        slverr_seen; // pslverr at the last access edge
	burst_link_if u_burst_link_if();
	// short refresh interval so variable reads collide often
	burst_memory_end #(.REFRESH_INTERVAL(16)) u_burst_memory_end (.pclk(pclk),
		.presetn(presetn), .link(u_burst_link_if), .refresh_busy(refresh_busy),
		.burst_active(burst_active));
	burst_controller_end #(.SELECT_LOW_MAX(160)) u_burst_controller_end (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link(u_burst_link_if));
	burst_link_checker #(.SEL_MAX(160)) u_burst_link_checker (.pclk(pclk), .presetn(presetn),
		.select_n(u_burst_link_if.select_n), .write_n(u_burst_link_if.write_n),
		.address_valid_strobe_n(u_burst_link_if.address_valid_strobe_n),
		.config_enable(u_burst_link_if.config_enable), .addr(u_burst_link_if.addr),
		.dev_dq_oe(u_burst_link_if.dev_dq_oe), .wait_pin(u_burst_link_if.wait_pin));
	// free running bus clock
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic tally_and_finish();
		if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish
	// one APB transfer; request held until pready is seen
	task automatic apb(input logic wr, input logic [7:0] off, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= {4'h0, off};
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		slverr_seen = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// poll busy; a hang is left to the watchdog
	task automatic idle(output logic [31:0] s);
		do apb(1'b0, burst_pkg::OFF_STATUS, 32'h0, s); while (s[0] === 1'b1);
	endtask : idle
	task automatic cfg(input logic fx, input logic [2:0] c, input logic pol, input logic wc,
		output logic [31:0] s);
		apb(1'b1, burst_pkg::OFF_CONFIG, {16'h0, 1'b0, fx, c, pol, 1'b0, wc, 8'h0f}, s);
		apb(1'b1, burst_pkg::OFF_CMD, 32'h4, s);
		idle(s);
	endtask : cfg
	// one burst, then the last read word
	task automatic burst(input logic rd, input logic [21:0] a, input logic [8:0] n,
		input logic [15:0] wd, output logic [31:0] q);
		apb(1'b1, burst_pkg::OFF_ADDR, {10'h0, a}, q);
		apb(1'b1, burst_pkg::OFF_LEN, {23'h0, n}, q);
		apb(1'b1, burst_pkg::OFF_WDATA, {16'h0, wd}, q);
		apb(1'b1, burst_pkg::OFF_CMD, rd ? 32'h1 : 32'h2, q);
		idle(q);
		apb(1'b0, burst_pkg::OFF_RDATA, 32'h0, q);
	endtask : burst
	task automatic t_reset();
		logic [31:0] d;
		logic        seen;
		seen = 1'b0;
		apb(1'b0, burst_pkg::OFF_CONFIG, 32'h0, d);
		`CHK(d, 32'h0000_1d0f)
		`CHK(slverr_seen, 1'b0)
		`CHK(u_burst_link_if.wait_pin, 1'b0)
		apb(1'b0, 8'h1c, 32'h0, d);
		`CHK(slverr_seen, 1'b1)
		// an idle refresh must run within one interval while deselected
		repeat (20) @(posedge pclk) if (refresh_busy) seen = 1'b1;
		`CHK(seen, 1'b1)
	endtask : t_reset
	// every legal mode and code, write then read back
	task automatic t_codes();
		logic [31:0] d;
		logic [15:0] wd;
		for (int f = 0; f < 2; f++) begin
			for (int c = 2; c <= (f ? 6 : 3); c++) begin
				wd = 16'h1000 * c[15:0] + f[15:0];
				cfg(f[0], c[2:0], 1'b1, c[0], d);
				`CHK(d[1], 1'b0)
				burst(1'b0, {16'h0, f[0], c[2:0], 2'h0}, 9'h4, wd, d);
				burst(1'b1, {16'h0, f[0], c[2:0], 2'h0}, 9'h4, 16'h0, d);
				`CHK(d[15:0], wd + 16'h3)
			end
		end
	endtask : t_codes
	// reserved codes are refused
	task automatic t_refuse();
		logic [31:0] d;
		for (int f = 0; f < 2; f++) begin
			for (int c = 0; c < 8; c++) begin
				if (c < 2 || c > (f ? 6 : 3)) begin
					cfg(f[0], c[2:0], 1'b1, 1'b1, d);
					`CHK(d[1], 1'b1)
				end
			end
		end
	endtask : t_refuse
	// active low wait, in-delay timing, variable read
	task automatic t_polarity();
		logic [31:0] d;
		cfg(1'b0, 3'h2, 1'b0, 1'b0, d);
		`CHK(u_burst_link_if.wait_pin, 1'b1)
		burst(1'b1, 22'h8, 9'h4, 16'h0, d);
		`CHK(d[15:0], 16'h2003)
		`CHK(burst_active, 1'b0)
	endtask : t_polarity
	// row end, then a burst long enough to hit the select limit
	task automatic t_row_long();
		logic [31:0] d;
		cfg(1'b1, 3'h3, 1'b1, 1'b1, d);
		burst(1'b0, 22'h0fc, 9'h6, 16'h5000, d);
		burst(1'b1, 22'h0ff, 9'h1, 16'h0, d);
		`CHK(d[15:0], 16'h5003)
		burst(1'b0, 22'h200, 9'd300, 16'h1000, d);
		burst(1'b1, 22'h200, 9'd300, 16'h0, d);
		`CHK(d[15:0], 16'h112b)
	endtask : t_row_long
	// watchdog, well above the expected run
	initial begin
		#(25 * 90000);
		err_count++;
		tally_and_finish();
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		err_count = 0;
		n_compared = 0;
		presetn = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_codes();
		t_refuse();
		t_polarity();
		t_row_long();
		tally_and_finish();
	end
endmodule : burst_latency_wait_control_tb
`default_nettype wire
